//--- core/ifc_pkg.sv
package ifc_pkg;
    // field positions, little-endian index of the 32-bit word (word bit 0 is index 31)
    localparam int unsigned IFC_W         = 32;
    localparam int unsigned IFC_PRI_HI    = 31;
    localparam int unsigned IFC_PRI_LO    = 26;
    localparam int unsigned IFC_XO_HI     = 10;
    localparam int unsigned IFC_XO_LO     = 1;
    localparam int unsigned IFC_B31       = 0;
    localparam int unsigned IFC_BOF_HI    = 25;
    localparam int unsigned IFC_BOF_LO    = 21;
    localparam int unsigned IFC_F11_HI    = 20;
    localparam int unsigned IFC_F11_LO    = 16;
    localparam int unsigned IFC_F16_HI    = 15;
    localparam int unsigned IFC_F16_LO    = 11;

    // primary opcodes
    localparam logic [5:0] IFC_OP_BC      = 6'h10;
    localparam logic [5:0] IFC_OP_X19     = 6'h13;
    localparam logic [5:0] IFC_OP_X31     = 6'h1f;

    // extended opcodes of the conditional branches and of forms with reserved fields
    localparam logic [9:0] IFC_XO_BCLR    = 10'h010;
    localparam logic [9:0] IFC_XO_BCCTR   = 10'h210;
    localparam logic [9:0] IFC_XO_SRIN_RD = 10'h293;
    localparam logic [9:0] IFC_XO_TLB_INV = 10'h132;
    localparam logic [9:0] IFC_XO_TLB_SYN = 10'h236;
    localparam logic [9:0] IFC_XO_SPR_WR  = 10'h1d3;
    // time-base write: split special-register number halves
    localparam logic [4:0] IFC_TB_HI      = 5'h08;
    localparam logic [4:0] IFC_TB_LO_L    = 5'h1c;
    localparam logic [4:0] IFC_TB_LO_U    = 5'h1d;

    // cause bits of the classification
    localparam int unsigned IFC_C_RSV     = 0;
    localparam int unsigned IFC_C_B31     = 1;
    localparam int unsigned IFC_C_BOF     = 2;

    // z bits of the branch_options_field, cleared when executing, and the branch-always value
    localparam logic [4:0] IFC_BO_SET_Z   = 5'h02;
    localparam logic [4:0] IFC_BO_DEC_Z   = 5'h08;
    localparam logic [4:0] IFC_BO_ALWAYS  = 5'h14;

    typedef struct packed {
        logic            valid;
        logic [IFC_W-1:0] instr;
        logic            invalid;
        logic [2:0]      cause;
    } ifc_state_t;
endpackage

//--- core/ifc_checker.sv
// What this block does
// - flag nonzero reserved fields in segment read, invalidate, time-base write, sync
// - flag set bit 31 in listed logical, indexed, string, trap, move forms
// - flag reserved branch_options_field encodings of conditional branches
// - a y position in a pattern matches both of its values
// - execute with offending bits replaced by their required values
// - branch_options_field check covers every conditional branch variant
`timescale 1ns/1ps
module ifc_checker (
    input  wire logic                      mclk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      instr_valid_in,
    input  wire logic [ifc_pkg::IFC_W-1:0] instr_in,
    output logic                           dec_valid_out,
    output logic [ifc_pkg::IFC_W-1:0]      dec_instr_out,
    output logic                           invalid_form_out,
    output logic [2:0]                     invalid_cause_out
);
    import ifc_pkg::*;

    function automatic logic ifc_is_b31_op(input logic [5:0] opc, input logic [9:0] ext);
        logic hit;
        hit = 1'b0;
        if (opc == IFC_OP_X19) begin
            unique case (ext)
                10'h1c1, 10'h0c1, 10'h0e1, 10'h021, 10'h081, 10'h121, 10'h1a1: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end else if (opc == IFC_OP_X31) begin
            unique case (ext)
                10'h057, 10'h077, 10'h117, 10'h137, 10'h157, 10'h177, 10'h017, 10'h037,
                10'h0d7, 10'h0f7, 10'h197, 10'h1b7, 10'h097, 10'h0b7,
                10'h316, 10'h216, 10'h396, 10'h296,
                10'h255, 10'h215, 10'h2d5, 10'h295, 10'h014, 10'h004, 10'h1d3, 10'h153,
                10'h217, 10'h237, 10'h257, 10'h277, 10'h297, 10'h2b7, 10'h2d7, 10'h2f7: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
        return hit;
    endfunction

    function automatic logic ifc_bo_bad(input logic [4:0] bo);
        return (bo[4:1] == 4'h3) || (bo[4:1] == 4'h7) || (bo[4:1] == 4'hc) || (bo[4:1] == 4'hd) ||
               (bo[4] && bo[2] && (bo[3] || bo[1] || bo[0]));
    endfunction

    // value executed in place of an invalid branch_options_field
    function automatic logic [4:0] ifc_bo_fix(input logic [4:0] bo);
        logic [4:0] r;
        r = bo;
        if (bo[4] && bo[2])
            r = IFC_BO_ALWAYS;
        else if (bo[4])
            r = bo & ~IFC_BO_DEC_Z;
        else
            r = bo & ~IFC_BO_SET_Z;
        return r;
    endfunction

    ifc_state_t        st;
    ifc_state_t        next_st;

    logic [5:0]        pri;
    logic [9:0]        xo;
    logic [4:0]        bof;
    logic              is_cbr;
    logic              srin_rd;
    logic              tlb_inv;
    logic              tb_wr;
    logic              tlb_syn;
    logic              rsv_bad;
    logic              b31_bad;
    logic              bof_bad;

    assign pri = instr_in[IFC_PRI_HI:IFC_PRI_LO];
    assign xo  = instr_in[IFC_XO_HI:IFC_XO_LO];
    assign bof = instr_in[IFC_BOF_HI:IFC_BOF_LO];

    assign is_cbr = (pri == IFC_OP_BC) ||
                    ((pri == IFC_OP_X19) && ((xo == IFC_XO_BCLR) || (xo == IFC_XO_BCCTR)));

    assign srin_rd = (pri == IFC_OP_X31) && (xo == IFC_XO_SRIN_RD);
    assign tlb_inv = (pri == IFC_OP_X31) && (xo == IFC_XO_TLB_INV);
    assign tlb_syn = (pri == IFC_OP_X31) && (xo == IFC_XO_TLB_SYN);
    // the special-register number sits in the 11..20 range, so only the source field is checked
    assign tb_wr   = (pri == IFC_OP_X31) && (xo == IFC_XO_SPR_WR) &&
                     (instr_in[IFC_F16_HI:IFC_F16_LO] == IFC_TB_HI) &&
                     ((instr_in[IFC_F11_HI:IFC_F11_LO] == IFC_TB_LO_L) ||
                      (instr_in[IFC_F11_HI:IFC_F11_LO] == IFC_TB_LO_U));

    assign rsv_bad = (srin_rd && (instr_in[IFC_F11_HI:IFC_F11_LO] != 5'h00)) ||
                     (tlb_inv && (instr_in[IFC_BOF_HI:IFC_F11_LO] != 10'h000)) ||
                     (tb_wr   && (instr_in[IFC_BOF_HI:IFC_BOF_LO] != 5'h00)) ||
                     (tlb_syn && (instr_in[IFC_BOF_HI:IFC_F16_LO] != 15'h0000));

    assign b31_bad = ifc_is_b31_op(pri, xo) && instr_in[IFC_B31];

    // y ignored by the 4-bit compares
    assign bof_bad = is_cbr && ifc_bo_bad(bof);

    always_comb begin
        next_st = st;
        // one word a cycle, flag beside it
        next_st.valid   = instr_valid_in;
        next_st.instr   = instr_in;
        next_st.invalid = 1'b0;
        next_st.cause   = 3'h0;
        if (instr_valid_in) begin
            next_st.cause[IFC_C_RSV] = rsv_bad;
            next_st.cause[IFC_C_B31] = b31_bad;
            next_st.cause[IFC_C_BOF] = bof_bad;
            next_st.invalid          = rsv_bad || b31_bad || bof_bad;
            if (rsv_bad && srin_rd)
                next_st.instr[IFC_F11_HI:IFC_F11_LO] = 5'h00;
            if (rsv_bad && tlb_inv)
                next_st.instr[IFC_BOF_HI:IFC_F11_LO] = 10'h000;
            if (rsv_bad && tb_wr)
                next_st.instr[IFC_BOF_HI:IFC_BOF_LO] = 5'h00;
            if (rsv_bad && tlb_syn)
                next_st.instr[IFC_BOF_HI:IFC_F16_LO] = 15'h0000;
            if (b31_bad)
                next_st.instr[IFC_B31] = 1'b0;
            if (bof_bad)
                next_st.instr[IFC_BOF_HI:IFC_BOF_LO] = ifc_bo_fix(bof);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dec_valid_out     = st.valid;
    assign dec_instr_out     = st.instr;
    assign invalid_form_out  = st.invalid;
    assign invalid_cause_out = st.cause;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    // raw decode for the checks, kept apart from the flag logic it guards
    logic raw_x31;
    logic raw_x19;
    logic raw_bc;

    assign raw_x31 = instr_valid_in && (pri == IFC_OP_X31);
    assign raw_x19 = instr_valid_in && (pri == IFC_OP_X19);
    assign raw_bc  = instr_valid_in && (pri == IFC_OP_BC);

    sequence s_sync_dirty;
        raw_x31 && (xo == IFC_XO_TLB_SYN) && (instr_in[IFC_BOF_HI:IFC_F16_LO] != 15'h0000);
    endsequence

    sequence s_sync_cleared;
        invalid_form_out && invalid_cause_out[IFC_C_RSV] && (dec_instr_out[IFC_BOF_HI:IFC_F16_LO] == 15'h0000);
    endsequence

    sequence s_inval_dirty;
        raw_x31 && (xo == IFC_XO_TLB_INV) && (instr_in[IFC_BOF_HI:IFC_F11_LO] != 10'h000);
    endsequence

    sequence s_inval_cleared;
        invalid_form_out && invalid_cause_out[IFC_C_RSV] && (dec_instr_out[IFC_BOF_HI:IFC_F11_LO] == 10'h000);
    endsequence

    sequence s_srin_dirty;
        raw_x31 && (xo == IFC_XO_SRIN_RD) && (instr_in[IFC_F11_HI:IFC_F11_LO] != 5'h00);
    endsequence

    sequence s_srin_cleared;
        invalid_form_out && invalid_cause_out[IFC_C_RSV] && (dec_instr_out[IFC_F11_HI:IFC_F11_LO] == 5'h00);
    endsequence

    sequence s_tb_dirty;
        raw_x31 && (xo == IFC_XO_SPR_WR) && (instr_in[IFC_F16_HI:IFC_F16_LO] == IFC_TB_HI) &&
        ((instr_in[IFC_F11_HI:IFC_F11_LO] == IFC_TB_LO_L) || (instr_in[IFC_F11_HI:IFC_F11_LO] == IFC_TB_LO_U)) &&
        (instr_in[IFC_BOF_HI:IFC_BOF_LO] != 5'h00);
    endsequence

    sequence s_tb_cleared;
        invalid_form_out && invalid_cause_out[IFC_C_RSV] && (dec_instr_out[IFC_BOF_HI:IFC_BOF_LO] == 5'h00);
    endsequence

    sequence s_load_b31;
        raw_x31 && (xo == 10'h057) && instr_in[IFC_B31];
    endsequence

    sequence s_crlogic_b31;
        raw_x19 && (xo == 10'h1c1) && instr_in[IFC_B31];
    endsequence

    sequence s_b31_cleared;
        invalid_form_out && invalid_cause_out[IFC_C_B31] && !dec_instr_out[IFC_B31];
    endsequence

    sequence s_bc_reserved;
        raw_bc && (bof == 5'h15);
    endsequence

    sequence s_bo_forced_always;
        invalid_cause_out[IFC_C_BOF] && (dec_instr_out[IFC_BOF_HI:IFC_BOF_LO] == IFC_BO_ALWAYS);
    endsequence

    property p_bo_ctr_cleared;
        raw_bc && (bof[4:1] == 4'hc) |=>
            invalid_cause_out[IFC_C_BOF] && (dec_instr_out[IFC_BOF_HI:IFC_BOF_LO] == {4'h8, $past(instr_in[IFC_BOF_LO])});
    endproperty

    property p_bo_y_both;
        raw_x19 && (xo == IFC_XO_BCLR) && (bof[4:1] == 4'h3) |=>
            invalid_cause_out[IFC_C_BOF] && (dec_instr_out[IFC_BOF_HI:IFC_BOF_LO] == {4'h2, $past(instr_in[IFC_BOF_LO])});
    endproperty

    property p_bcctr_covered;
        raw_x19 && (xo == IFC_XO_BCCTR) && (bof == 5'h1f) |=> invalid_form_out && invalid_cause_out[IFC_C_BOF];
    endproperty

    a_sync_reserved_field: assert property (s_sync_dirty |=> s_sync_cleared)
        else $error("reserved sync field not flagged or not cleared");

    a_inval_reserved_field: assert property (s_inval_dirty |=> s_inval_cleared)
        else $error("reserved invalidate field not flagged or not cleared");

    a_segment_read_field: assert property (s_srin_dirty |=> s_srin_cleared)
        else $error("reserved segment read field not flagged or not cleared");

    a_timebase_reserved: assert property (s_tb_dirty |=> s_tb_cleared)
        else $error("reserved time-base write field not flagged or not cleared");

    a_bit31_flag_clear: assert property (s_load_b31 |=> s_b31_cleared)
        else $error("indexed load bit 31 not flagged");

    a_crlogic_bit31: assert property (s_crlogic_b31 |=> s_b31_cleared)
        else $error("condition logic bit 31 not flagged");

    a_bo_reserved_hit: assert property (s_bc_reserved |=> s_bo_forced_always)
        else $error("reserved branch encoding missed");

    a_bo_ctr_cleared: assert property (p_bo_ctr_cleared)
        else $error("reserved counter branch encoding not forced");

    a_bo_y_both: assert property (p_bo_y_both)
        else $error("y position not treated as both values");

    a_fixed_word_valid: assert property (invalid_cause_out[IFC_C_BOF] |-> !ifc_bo_bad(dec_instr_out[IFC_BOF_HI:IFC_BOF_LO]))
        else $error("executed word still carries invalid bits");

    a_clean_word_kept: assert property (dec_valid_out && !invalid_form_out |-> (dec_instr_out == $past(instr_in)))
        else $error("valid form word altered");

    a_bcctr_covered: assert property (p_bcctr_covered)
        else $error("count-register branch not checked");

    a_flag_same_word: assert property (dec_valid_out == $past(instr_valid_in))
        else $error("flag not aligned with its word");

    a_idle_flag_low: assert property (!dec_valid_out |-> !invalid_form_out && (invalid_cause_out == 3'h0))
        else $error("flag raised without a word");

    a_flag_from_cause: assert property (invalid_form_out == (invalid_cause_out != 3'h0))
        else $error("flag and cause disagree");

endmodule // ifc_checker

//--- sim/ifc_fetch_model.sv
`timescale 1ns/1ps
module ifc_fetch_model (
    input  wire logic        mclk_in,
    output logic             valid_out,
    output logic [31:0]      instr_out
);
    initial begin
        valid_out = 1'b0;
        instr_out = 32'h0;
    end
    // idle cycles flip the stale word so it never passes for a live one
    task automatic issue(input logic [31:0] w, input logic v, input int unsigned idle);
        repeat (idle) begin
            @(posedge mclk_in);
            #1;
            valid_out = 1'b0;
            instr_out = ~instr_out;
        end
        @(posedge mclk_in);
        #1;
        valid_out = v;
        instr_out = w;
    endtask
endmodule // ifc_fetch_model

//--- sim/ifc_checker_tb.sv
`timescale 1ns/1ps
module ifc_checker_tb;
    import ifc_pkg::*;
    logic        mclk_in, rst_n_in, valid, dec_valid, inv, cur_v;
    logic [31:0] instr, dec_instr, cur_w, seed, w;
    logic [2:0]  cause;
    logic [35:0] ex;
    logic [9:0]  xo_tab [16] = '{10'h293, 10'h132, 10'h236, 10'h1d3, 10'h057, 10'h2d5, 10'h014, 10'h153,
                                 10'h217, 10'h2f7, 10'h1c1, 10'h021, 10'h1a1, 10'h010, 10'h210, 10'h0c1};
    int          bad_count, checks_done, cycles;
    ifc_fetch_model u_ifc_fetch_model (.mclk_in(mclk_in), .valid_out(valid), .instr_out(instr));
    ifc_checker u_ifc_checker (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .instr_valid_in(valid),
        .instr_in(instr), .dec_valid_out(dec_valid), .dec_instr_out(dec_instr),
        .invalid_form_out(inv), .invalid_cause_out(cause));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // returns {flag, cause, word as executed}
    function automatic logic [35:0] expect_of(input logic [31:0] i);
        logic [2:0] c;
        logic [31:0] m;
        logic [4:0] b;
        c = 3'h0;
        m = 32'h0;
        b = i[25:21];
        if (i[31:26] == 6'h1f) begin
            case (i[10:1])
                10'h293: m = 32'h001f0000;
                10'h132: m = 32'h03ff0000;
                10'h236: m = 32'h03fff800;
                10'h1d3: m = (i[15:11] == 5'h08 && i[20:17] == 4'he) ? 32'h03e00000 : 32'h0;
                default: m = 32'h0;
            endcase
        end
        c[0] = |(i & m);
        i = i & ~m;
        if (i[0] && ((i[31:26] == 6'h13 && i[10:1] inside {10'h1c1, 10'h0c1, 10'h0e1, 10'h021, 10'h081,
            10'h121, 10'h1a1}) || (i[31:26] == 6'h1f &&
            i[10:1] inside {10'h057, 10'h077, 10'h117, 10'h137, 10'h157, 10'h177, 10'h017, 10'h037, 10'h0d7,
            10'h0f7, 10'h197, 10'h1b7, 10'h097, 10'h0b7, 10'h316, 10'h216, 10'h396, 10'h296, 10'h255, 10'h215,
            10'h2d5, 10'h295, 10'h014, 10'h004, 10'h1d3, 10'h153, 10'h217, 10'h237, 10'h257, 10'h277, 10'h297,
            10'h2b7, 10'h2d7, 10'h2f7}))) begin
            c[1] = 1'b1;
            i[0] = 1'b0;
        end
        if ((i[31:26] == 6'h10 || (i[31:26] == 6'h13 && i[10:1] inside {10'h010, 10'h210})) &&
            (b[4:1] inside {4'h3, 4'h7, 4'hc, 4'hd} || b inside {[5'h15:5'h17], [5'h1c:5'h1f]})) begin
            c[2] = 1'b1;
            i[25:21] = (b[4] && b[2]) ? 5'h14 : (b & (b[4] ? 5'h17 : 5'h1d));
        end
        return {|c, c, i};
    endfunction
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask
    task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cur_v <= rst_n_in & valid;
        cur_w <= instr;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    always @(negedge mclk_in) begin
        ex = expect_of(cur_w);
        chk_bit(dec_valid, rst_n_in & cur_v, "valid");
        if (rst_n_in && cur_v) begin
            chk_bit(inv, ex[35], "flag");
            chk_vec({29'h0, cause}, {29'h0, ex[34:32]}, "cause");
            chk_vec(dec_instr, ex[31:0], "word");
        end else begin
            chk_bit(inv, 1'b0, "idle flag");
            chk_vec({29'h0, cause}, 32'h0, "idle cause");
        end
    end
    initial begin
        rst_n_in = 1'b0;
        seed = 32'h42;
        cycles = 0;
        repeat (12) @(posedge mclk_in);
        #1 rst_n_in = 1'b1;
        u_ifc_fetch_model.issue({6'h1f, 5'h1f, 5'h1c, 5'h08, 10'h1d3, 1'b1}, 1'b1, 0);
        u_ifc_fetch_model.issue({6'h1f, 15'h7fff, 10'h236, 1'b0}, 1'b1, 0);
        u_ifc_fetch_model.issue({6'h1f, 5'h03, 5'h1f, 5'h00, 10'h293, 1'b0}, 1'b1, 0);
        u_ifc_fetch_model.issue({6'h1f, 10'h3ff, 5'h04, 10'h132, 1'b0}, 1'b1, 0);
        // every branch field value on each conditional branch form
        for (int b = 0; b < 96; b++) begin
            seed = lfsr(seed);
            w = {b < 32 ? 6'h10 : 6'h13, b[4:0], seed[20:11], b < 64 ? 10'h010 : 10'h210, seed[0]};
            u_ifc_fetch_model.issue(w, 1'b1, 0);
        end
        for (int n = 0; n < 3000; n++) begin
            seed = lfsr(seed);
            w = lfsr(seed);
            if (!seed[17]) w[31:26] = seed[3] ? 6'h1f : 6'h13;
            if (!seed[17]) w[10:1] = xo_tab[seed[7:4]];
            if (seed[8]) w[25:11] = 15'h0;
            if (seed[9]) w[20:11] = {4'he, seed[10], 5'h08};
            u_ifc_fetch_model.issue(w, seed[15] | seed[16], seed[12:11] == 2'h0 ? seed[14:13] : 0);
        end
        u_ifc_fetch_model.issue(32'h0, 1'b0, 2);
        complete_run();
    end
endmodule // ifc_checker_tb
